// ==== rtl/acc_ctrl.v ====
/*
 * converter conversion control: registers, start logic, auto trigger,
 * result locking and the completion flag toward the interrupt controller.
 * assumes an analog core that presents its code on core_code_in when
 * sampled, and trigger sources synchronous to clock_in.
 */
// Notes on behaviour
// RL1: low read locks result, next result dropped
// RL2: high byte read unlocks result registers
// RL3: completion flag set even when result dropped
// RL4: software clears power bit, writes start
// RL5: start bit held until conversion ends
// RL6: channel latched at start, changes wait
// RL7: auto trigger enable, source from select field
// RL8: trigger rise restarts prescaler and converts
// RL9: trigger still high at end: no restart
// RL10: rise during conversion ignored, not queued
// RL11: flag set regardless of interrupt enables
// RL12: software clears flag for next flag trigger
// RL13: own flag as trigger gives free running
// RL14: free running ignores flag clearing
// RL15: software starts first free running conversion
// RL16: software start works with auto trigger
// RL17: start bit reads one during any conversion
// RL18: result stored on the same edge the flag rises
// RL19: single ended code vin*1024/vref, 10 bits
// RL20: temperature needs sensor channel, 1.1V reference
// RL21: temperature sensor is a mux channel
// RL22: conversion latency is a parameter
`timescale 1ns/1ps
`include "acc_defs.vh"
module acc_ctrl #(
	parameter CONV_CYCLES = `ACC_CONV_CYCLES
) (
	input  wire       clock_in,
	input  wire       rstn_in,
	input  wire [7:0] addr_in,
	input  wire [7:0] wdata_in,
	input  wire       wr_in,
	input  wire       rd_in,
	output reg  [7:0] rdata_out,
	input  wire [7:1] trig_src_in,
	input  wire [9:0] core_code_in,
	output reg  [4:0] core_chan_out,
	output reg  [1:0] core_ref_out,
	output reg        core_sample_out,
	output reg        core_on_out,
	output reg        irq_out
);
	localparam ST_IDLE = 2'b01;
	localparam ST_CONV = 2'b10;
	// last tick index of a conversion, cut to the counter width on purpose
	localparam integer LAST_INT = CONV_CYCLES - 1;
	localparam [5:0]   LAST_CYC = LAST_INT[5:0];

	reg  [1:0] state_ff;
	reg  [1:0] nxt_state;
	reg  [7:0] ctrl_a_ff;
	reg  [2:0] tsel_ff;
	reg  [7:0] mux_ff;
	reg        power_off_ff;
	reg  [9:0] result_ff;
	reg        locked_ff;
	reg  [5:0] cyc_ff;
	reg        done_flag_ff;
	reg        start_req_ff;

	wire       trig_level;
	wire       trig_rise;
	wire       tick;
	wire       enabled;
	wire       wr_a;
	wire       sw_start;
	wire       auto_on;
	wire       free_run;
	wire       go;
	wire       finish;
	wire [7:0] res_lo;
	wire [7:0] res_hi;

	assign enabled  = ctrl_a_ff[`ACC_A_ENABLE] & ~power_off_ff;
	assign wr_a     = wr_in & (addr_in == `ACC_OFF_CTRL_A);
	// enable and start may arrive in one write, so the written enable counts
	assign sw_start = wr_a & wdata_in[`ACC_A_START] & wdata_in[`ACC_A_ENABLE] & ~power_off_ff; // [RL4] [RL15] [RL16]
	assign auto_on  = ctrl_a_ff[`ACC_A_AUTO_TRIG]; // [RL7]
	assign free_run = auto_on & (tsel_ff == `ACC_TSEL_FREE); // [RL13]
	assign finish   = (state_ff == ST_CONV) & tick & (cyc_ff == LAST_CYC); // [RL22]

	// edge start only from idle, rises inside a conversion are dropped
	assign go = (state_ff == ST_IDLE) & enabled &
		(start_req_ff | (auto_on & ~free_run & trig_rise)); // [RL8] [RL9] [RL10] [RL12]

	// source 0 is the own completion flag, others come from outside
	acc_trig u_trig (
		.clock_in  (clock_in),
		.rstn_in   (rstn_in),
		.sources_in({trig_src_in, done_flag_ff}),
		.sel_in    (tsel_ff),
		.level_out (trig_level),
		.rise_out  (trig_rise)
	);

	acc_presc u_presc (
		.clock_in  (clock_in),
		.rstn_in   (rstn_in),
		.restart_in(go), // [RL8]
		.sel_in    (ctrl_a_ff[`ACC_A_PRESC_HI:`ACC_A_PRESC_LO]),
		.tick_out  (tick)
	);

	// next state
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: if (go) nxt_state = ST_CONV;
			ST_CONV: begin
				if (!enabled)
					nxt_state = ST_IDLE;
				else if (finish && !free_run)
					nxt_state = ST_IDLE;
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	// state, cycle count and latched channel
	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_ff      <= ST_IDLE;
			cyc_ff        <= 6'h00;
			core_chan_out <= 5'h00;
			core_ref_out  <= 2'h0;
		end else begin
			state_ff <= nxt_state;
			if (go || (finish && free_run)) begin
				cyc_ff        <= 6'h00;
				core_chan_out <= mux_ff[`ACC_M_CHAN_HI:`ACC_M_CHAN_LO]; // [RL6] [RL21]
				core_ref_out  <= mux_ff[`ACC_M_REF_HI:`ACC_M_REF_LO]; // [RL20]
			end else if (state_ff == ST_CONV && tick) begin
				cyc_ff <= cyc_ff + 6'h01;
			end
		end
	end

	// pending software start, kept until idle takes it or the converter is disabled
	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in)
			start_req_ff <= 1'b0;
		else if (sw_start && !go)
			start_req_ff <= 1'b1;
		else if (!enabled || go)
			start_req_ff <= 1'b0;
	end

	// software registers
	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl_a_ff    <= `ACC_RST_CTRL_A;
			tsel_ff      <= `ACC_RST_TSEL;
			mux_ff       <= `ACC_RST_MUX_SEL;
			power_off_ff <= 1'b1;
		end else if (wr_in) begin
			case (addr_in)
				`ACC_OFF_CTRL_A: begin
					ctrl_a_ff[`ACC_A_ENABLE]    <= wdata_in[`ACC_A_ENABLE];
					ctrl_a_ff[`ACC_A_AUTO_TRIG] <= wdata_in[`ACC_A_AUTO_TRIG];
					ctrl_a_ff[`ACC_A_IRQ_EN]    <= wdata_in[`ACC_A_IRQ_EN];
					ctrl_a_ff[2:0]              <= wdata_in[2:0];
				end
				`ACC_OFF_CTRL_B:  tsel_ff      <= wdata_in[`ACC_B_TSEL_HI:`ACC_B_TSEL_LO];
				`ACC_OFF_MUX_SEL: mux_ff       <= wdata_in;
				`ACC_OFF_POWER:   power_off_ff <= wdata_in[`ACC_P_CONV_OFF];
				default: ;
			endcase
		end
	end

	// completion flag: set wins over write-one clear
	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in)
			done_flag_ff <= 1'b0;
		else if (finish)
			done_flag_ff <= 1'b1; // [RL3] [RL11] [RL14]
		else if (wr_a && wdata_in[`ACC_A_DONE_FLAG])
			done_flag_ff <= 1'b0;
	end

	// result capture and read lock
	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			result_ff <= 10'h000;
			locked_ff <= 1'b0;
		end else begin
			if (finish && !locked_ff)
				result_ff <= core_code_in; // [RL1] [RL13] [RL18] [RL19]
			if (rd_in && addr_in == `ACC_OFF_RESULT_HIGH)
				locked_ff <= 1'b0; // [RL2]
			else if (rd_in && addr_in == `ACC_OFF_RESULT_LOW)
				locked_ff <= 1'b1; // [RL1]
		end
	end

	// left adjust option for the two result bytes
	assign res_lo = mux_ff[`ACC_M_LEFT_ADJ] ? {result_ff[1:0], 6'h00} : result_ff[7:0];
	assign res_hi = mux_ff[`ACC_M_LEFT_ADJ] ? result_ff[9:2] : {6'h00, result_ff[9:8]};

	// read data one cycle after the strobe
	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rdata_out <= 8'h00;
		end else if (rd_in) begin
			case (addr_in)
				`ACC_OFF_RESULT_LOW:  rdata_out <= res_lo;
				`ACC_OFF_RESULT_HIGH: rdata_out <= res_hi;
				`ACC_OFF_CTRL_A: rdata_out <= {ctrl_a_ff[7], (state_ff == ST_CONV) | start_req_ff,
					ctrl_a_ff[5], done_flag_ff, ctrl_a_ff[3:0]}; // [RL5] [RL17]
				`ACC_OFF_CTRL_B:  rdata_out <= {5'h00, tsel_ff};
				`ACC_OFF_MUX_SEL: rdata_out <= mux_ff;
				`ACC_OFF_POWER:   rdata_out <= {7'h00, power_off_ff};
				default:          rdata_out <= 8'h00;
			endcase
		end else begin
			rdata_out <= 8'h00;
		end
	end

	// core strobes and interrupt request level
	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			core_sample_out <= 1'b0;
			core_on_out     <= 1'b0;
			irq_out         <= 1'b0;
		end else begin
			core_sample_out <= go | (finish & free_run);
			core_on_out     <= enabled;
			irq_out         <= (done_flag_ff | finish) & ctrl_a_ff[`ACC_A_IRQ_EN];
		end
	end
endmodule // acc_ctrl

// ==== rtl/acc_defs.vh ====
/*
 * constants for the converter control block: register offsets, field
 * positions, reset values and timing counts.
 * assumes inclusion by bare name from the design files.
 */
`ifndef ACC_DEFS_VH
`define ACC_DEFS_VH

// register offsets on the plain register port
`define ACC_OFF_RESULT_LOW     8'h78
`define ACC_OFF_RESULT_HIGH    8'h79
`define ACC_OFF_CTRL_A         8'h7A
`define ACC_OFF_CTRL_B         8'h7B
`define ACC_OFF_MUX_SEL        8'h7C
`define ACC_OFF_POWER          8'h64

// control/status a fields
`define ACC_A_ENABLE           7
`define ACC_A_START            6
`define ACC_A_AUTO_TRIG        5
`define ACC_A_DONE_FLAG        4
`define ACC_A_IRQ_EN           3
`define ACC_A_PRESC_HI         2
`define ACC_A_PRESC_LO         0

// control/status b fields
`define ACC_B_TSEL_HI          2
`define ACC_B_TSEL_LO          0

// multiplexer selection fields
`define ACC_M_REF_HI           7
`define ACC_M_REF_LO           6
`define ACC_M_LEFT_ADJ         5
`define ACC_M_CHAN_HI          4
`define ACC_M_CHAN_LO          0

// power register field
`define ACC_P_CONV_OFF         0

// trigger select code for free running
`define ACC_TSEL_FREE          3'h0

// reset values
`define ACC_RST_CTRL_A         8'h00
`define ACC_RST_CTRL_B         8'h00
`define ACC_RST_MUX_SEL        8'h00
`define ACC_RST_POWER          8'h01
`define ACC_RST_TSEL           3'h0

// conversion latency in prescaled converter clocks
`define ACC_CONV_CYCLES        13

`endif

// ==== rtl/acc_presc.v ====
/*
 * conversion clock prescaler: emits a one-cycle tick every 2^n system clocks, n the selector and 0 taken as 1,
 * with a synchronous restart.
 * assumes a single clock and the selector held stable by software.
 */
`timescale 1ns/1ps
module acc_presc (
	input  wire       clock_in,
	input  wire       rstn_in,
	input  wire       restart_in,
	input  wire [2:0] sel_in,
	output reg        tick_out
);
	reg  [6:0] cnt_ff;
	reg  [6:0] lim;

	// divide ratio, selector 0 and 1 both divide by two
	always @* begin
		case (sel_in)
			3'h0, 3'h1: lim = 7'h01;
			3'h2: lim = 7'h03;
			3'h3: lim = 7'h07;
			3'h4: lim = 7'h0F;
			3'h5: lim = 7'h1F;
			3'h6: lim = 7'h3F;
			default: lim = 7'h7F;
		endcase
	end

	// counter with restart
	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt_ff   <= 7'h00;
			tick_out <= 1'b0;
		end else if (restart_in) begin
			cnt_ff   <= 7'h00;
			tick_out <= 1'b0;
		end else if (cnt_ff >= lim) begin
			cnt_ff   <= 7'h00;
			tick_out <= 1'b1;
		end else begin
			cnt_ff   <= cnt_ff + 7'h01;
			tick_out <= 1'b0;
		end
	end
endmodule // acc_presc

// ==== rtl/acc_trig.v ====
/*
 * trigger selector and rising edge detector for auto triggering.
 * assumes trigger sources synchronous to the clock.
 */
`timescale 1ns/1ps
module acc_trig (
	input  wire       clock_in,
	input  wire       rstn_in,
	input  wire [7:0] sources_in,
	input  wire [2:0] sel_in,
	output wire       level_out,
	output wire       rise_out
);
	reg  prev_ff;

	assign level_out = sources_in[sel_in];
	assign rise_out  = level_out & ~prev_ff;

	// previous level of the chosen source
	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in)
			prev_ff <= 1'b0;
		else
			prev_ff <= level_out;
	end
endmodule // acc_trig

// ==== tb/acc_core_model.sv ====
/*
 * analog core stand-in: latches a code from the channel at each sample.
 * assumes the control block samples core_code_in in its finishing cycle.
 */
`timescale 1ns/1ps
module acc_core_model (
	input  wire       clock_in,
	input  wire [4:0] chan_in,
	input  wire       sample_in,
	output reg  [9:0] code_out
);
	// code within 0x000..0x3ff, derived from the channel held at sampling
	initial code_out = 10'h000;
	always @(posedge clock_in) begin
		if (sample_in)
			code_out <= {chan_in, 5'h0a};
	end
endmodule // acc_core_model

// ==== tb/acc_props.sv ====
/*
 * port checker for the conversion control block.
 * assumes binding to acc_ctrl, one clock and asynchronous reset.
 */
`timescale 1ns/1ps
module acc_props #(
	parameter CONV_CYCLES = 13
) (
	input wire       clock_in,
	input wire       rstn_in,
	input wire [7:0] addr_in,
	input wire [7:0] wdata_in,
	input wire       wr_in,
	input wire       rd_in,
	input wire [7:0] rdata_out,
	input wire [4:0] core_chan_out,
	input wire [1:0] core_ref_out,
	input wire       core_sample_out,
	input wire       core_on_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rstn_in);
	// read port behaviour
	a_read_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
		else $error("read data not zero outside answer cycle");
	a_unmapped_zero: assert property (rd_in && !(addr_in inside {8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h64})
		|=> rdata_out == 8'h00) else $error("unmapped read not zero");
	a_ctrlb_reserved: assert property (rd_in && addr_in == 8'h7b |=> rdata_out[7:3] == 5'h00)
		else $error("control b upper bits not zero");
	// conversion start and power off behaviour
	a_chan_latched: assert property (!$stable(core_chan_out) |-> ##[0:1] core_sample_out)
		else $error("channel changed outside conversion start");
	a_ref_latched: assert property (!$stable(core_ref_out) |-> ##[0:1] core_sample_out)
		else $error("reference changed outside conversion start");
	a_sample_pulse: assert property (core_sample_out |=> !core_sample_out)
		else $error("sample pulse longer than one cycle");
	a_start_reads_one: assert property (rd_in && addr_in == 8'h7a && core_sample_out |=> rdata_out[6])
		else $error("start bit low during conversion");
	a_power_off: assert property (wr_in && addr_in == 8'h64 && wdata_in[0] |-> ##[1:2] !core_on_out)
		else $error("core still on after power off");
	// main scenarios
	c_sample: cover property (core_sample_out);
	c_low_read: cover property (rd_in && addr_in == 8'h78);
	c_int_ref: cover property (core_ref_out == 2'b11);
endmodule // acc_props
bind acc_ctrl acc_props #(.CONV_CYCLES(CONV_CYCLES)) props_u (.clock_in(clock_in), .rstn_in(rstn_in),
	.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
	.core_chan_out(core_chan_out), .core_ref_out(core_ref_out), .core_sample_out(core_sample_out),
	.core_on_out(core_on_out));

// ==== tb/acc_ctrl_tb_top.sv ====
/*
 * testbench for the conversion control block: register tests and triggers.
 * assumes the core model beside it and a short conversion parameter.
 */
`timescale 1ns/1ps
module acc_ctrl_tb_top;
	logic       clock_in = 1'b0;
	logic       rstn_in = 1'b0;
	logic [7:0] addr_in = 8'h00;
	logic [7:0] wdata_in = 8'h00;
	logic       wr_in = 1'b0;
	logic       rd_in = 1'b0;
	logic [7:1] trig = 7'h00;
	logic [7:0] rdata_out;
	logic [7:0] v;
	logic [4:0] chan;
	logic [1:0] ref_sel;
	logic       smp;
	logic [9:0] code;
	logic       irq;
	int         miscompares = 0;
	int         num_checks = 0;
	int         samples = 0;
	int         s0;
	acc_ctrl #(.CONV_CYCLES(4)) dut_u (.clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .trig_src_in(trig),
		.core_code_in(code), .core_chan_out(chan), .core_ref_out(ref_sel), .core_sample_out(smp),
		.core_on_out(), .irq_out(irq));
	acc_core_model core_u (.clock_in(clock_in), .chan_in(chan), .sample_in(smp), .code_out(code));
	// clock and sample counter
	initial forever #25 clock_in = ~clock_in;
	always @(posedge clock_in) begin
		if (smp === 1'b1)
			samples <= samples + 1;
	end
	task chk(input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e)
			$display("BAD %0t seen %h exp %h", $time, s, e);
		if (s !== e)
			miscompares++;
	endtask
	// register port cycles
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clock_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
		#1 v = rdata_out;
	endtask
	task rc(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk(v, e);
	endtask
	// poll until the start bit drops, bounded
	task wdone;
		for (int i = 0; i < 100; i++) begin
			rd(8'h7a);
			if (v[6] === 1'b0)
				break;
		end
		chk(v & 8'h40, 8'h00);
	endtask
	task conv(input logic [7:0] m, input logic [7:0] lo, input logic [7:0] hi);
		wr(8'h7c, m);
		wr(8'h7a, 8'hd3);
		wdone;
		rc(8'h78, lo);
		rc(8'h79, hi);
	endtask
	task stop_test;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// hang guard
	initial begin
		#2_000_000;
		miscompares++;
		stop_test;
	end
	// test sequence
	initial begin
		repeat (4) @(posedge clock_in);
		rstn_in <= 1'b1;
		rc(8'h7a, 8'h00);
		rc(8'h64, 8'h01);
		rc(8'h7c, 8'h00);
		rc(8'h10, 8'h00);
		$display("end reset values");
		wr(8'h64, 8'h00);
		wr(8'h7c, 8'h03);
		wr(8'h7a, 8'hc3);
		rc(8'h7a, 8'hc3);
		wr(8'h7c, 8'h05);
		wdone;
		rc(8'h7a, 8'h93);
		rc(8'h78, 8'h6a);
		rc(8'h79, 8'h00);
		$display("end single conversion");
		rc(8'h78, 8'h6a);
		wr(8'h7a, 8'hdb);
		wdone;
		chk({7'h00, irq}, 8'h01);
		rc(8'h7a, 8'h9b);
		rc(8'h78, 8'h6a);
		rc(8'h79, 8'h00);
		conv(8'h05, 8'haa, 8'h00);
		chk({7'h00, irq}, 8'h00);
		conv(8'hdb, 8'h6a, 8'h03);
		$display("end result locking");
		wr(8'h7b, 8'h01);
		wr(8'h7a, 8'hb3);
		s0 = samples;
		@(posedge clock_in);
		trig <= 7'h01;
		repeat (6) @(posedge clock_in);
		trig <= 7'h00;
		@(posedge clock_in);
		trig <= 7'h01;
		repeat (100) @(posedge clock_in);
		chk(8'(samples - s0), 8'h01);
		trig <= 7'h00;
		s0 = samples;
		wr(8'h7a, 8'hf3);
		repeat (60) @(posedge clock_in);
		chk(8'(samples - s0), 8'h01);
		$display("end auto trigger");
		wr(8'h7b, 8'h00);
		s0 = samples;
		wr(8'h7a, 8'he3);
		repeat (100) @(posedge clock_in);
		chk({7'h00, samples - s0 >= 3}, 8'h01);
		wr(8'h7a, 8'hb3);
		s0 = samples;
		repeat (75) @(posedge clock_in);
		chk({7'h00, samples - s0 >= 2}, 8'h01);
		wr(8'h7a, 8'h00);
		wr(8'h64, 8'h01);
		wr(8'h7a, 8'hd3);
		rc(8'h7a, 8'h83);
		$display("end free running");
		stop_test;
	end
endmodule // acc_ctrl_tb_top
